/* File: core/safeload_param_transfer.sv */
module safeload_param_transfer
    import stage_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Frame pacing
    input  wire logic       frame_tick,
    // Host parameter write port
    input  wire mem_wr_type host_wr,
    // Parameter RAM write port
    output mem_wr_type      ram_wr,
    // Status
    output logic            busy,
    output logic            done
);
    logic [DATA_W-1:0] slot_r [SLOTS];
    logic [DATA_W-1:0] slot_nxt [SLOTS];
    logic [ADDR_W-1:0] taddr_r, taddr_nxt;
    logic [CNT_W-1:0]  count_r, count_nxt;
    logic              armed_r, armed_nxt;
    state_type         state_r, state_nxt;
    logic [CNT_W-1:0]  idx_r, idx_nxt;
    logic [CNT_W-1:0]  len_r, len_nxt;
    mem_wr_type        ram_wr_r, ram_wr_nxt;
    logic              done_r, done_nxt;
    logic              cnt_wr;
    logic              start;

    assign cnt_wr = host_wr.en && host_wr.addr == COUNT_ADDR;
    assign start  = frame_tick && state_r == IDLE && armed_r;

    always_comb begin
        for (int i = 0; i < SLOTS; i++) begin
            slot_nxt[i] = slot_r[i];
            if (host_wr.en && host_wr.addr == SLOT0_ADDR + ADDR_W'(i)) begin
                slot_nxt[i] = host_wr.data;
            end
        end
        taddr_nxt = taddr_r;
        if (host_wr.en && host_wr.addr == TADDR_ADDR) begin
            taddr_nxt = host_wr.data[ADDR_W-1:0];
        end
        count_nxt = count_r;
        armed_nxt = armed_r;
        if (start) begin
            armed_nxt = 1'b0;
        end
        if (cnt_wr) begin
            count_nxt = host_wr.data[CNT_W-1:0];
            armed_nxt = 1'b1;
        end
    end

    // Out-of-range counts are clamped so the copy never leaves the slots
    always_comb begin
        state_nxt  = state_r;
        idx_nxt    = idx_r;
        len_nxt    = len_r;
        ram_wr_nxt = '0;
        done_nxt   = 1'b0;
        unique case (state_r)
            IDLE: begin
                if (start && count_r != CNT_ZERO) begin
                    state_nxt = COPY;
                    idx_nxt   = '0;
                    len_nxt   = (count_r > CNT_MAX) ? CNT_MAX : count_r;
                end
            end
            COPY: begin
                ram_wr_nxt.en   = 1'b1;
                ram_wr_nxt.addr = taddr_r + ADDR_W'(idx_r);
                ram_wr_nxt.data = slot_r[idx_r];
                idx_nxt         = idx_r + CNT_W'(1);
                // burst finishes in a few cycles
                if (idx_nxt >= len_r) begin
                    state_nxt = IDLE;
                    done_nxt  = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < SLOTS; i++) begin
                slot_r[i] <= '0;
            end
            taddr_r  <= '0;
            count_r  <= '0;
            armed_r  <= 1'b0;
            state_r  <= IDLE;
            idx_r    <= '0;
            len_r    <= '0;
            ram_wr_r <= '0;
            done_r   <= 1'b0;
        end else begin
            slot_r   <= slot_nxt;
            taddr_r  <= taddr_nxt;
            count_r  <= count_nxt;
            armed_r  <= armed_nxt;
            state_r  <= state_nxt;
            idx_r    <= idx_nxt;
            len_r    <= len_nxt;
            ram_wr_r <= ram_wr_nxt;
            done_r   <= done_nxt;
        end
    end

    assign ram_wr = ram_wr_r;
    assign busy   = state_r == COPY;
    assign done   = done_r;

    // Checker helper: word number inside a burst
    logic [CNT_W-1:0] word_r, word_nxt;
    always_comb begin
        word_nxt = '0;
        if (ram_wr_r.en) begin
            word_nxt = word_r + CNT_W'(1);
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            word_r <= '0;
        end else begin
            word_r <= word_nxt;
        end
    end

    // Armed request starts on the tick
    start_on_tick_a: assert property (@(posedge clk) disable iff (!rstn)
        start && count_r >= CNT_MIN && count_r <= CNT_MAX |=> state_r == COPY)
        else $error("armed request not started on frame tick");
    // First word to the target address
    first_addr_a: assert property (@(posedge clk) disable iff (!rstn)
        state_r == IDLE ##1 state_r == COPY |=> ram_wr.en && ram_wr.addr == $past(taddr_r))
        else $error("first word not at target address");
    // Addresses step by one
    addr_step_a: assert property (@(posedge clk) disable iff (!rstn)
        ram_wr.en && $past(ram_wr.en) |-> ram_wr.addr == $past(ram_wr.addr) + ADDR_W'(1))
        else $error("target address did not step by one");
    // Count write arms
    count_arms_a: assert property (@(posedge clk) disable iff (!rstn)
        cnt_wr |=> armed_r && count_r == $past(host_wr.data[CNT_W-1:0]))
        else $error("count write did not arm");
    // Trigger cleared after start
    trigger_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        start && !cnt_wr |=> !armed_r)
        else $error("trigger not cleared after service");
    // Burst ends within five writes
    burst_bound_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(busy) |-> ##[1:5] !busy)
        else $error("copy burst too long");
    // Slot write lands
    slot_store_a: assert property (@(posedge clk) disable iff (!rstn)
        host_wr.en && host_wr.addr == SLOT0_ADDR |=> slot_r[0] == $past(host_wr.data))
        else $error("slot 0 not stored");
    // No start without a tick
    no_tick_a: assert property (@(posedge clk) disable iff (!rstn)
        !frame_tick && state_r == IDLE |=> state_r == IDLE)
        else $error("copy started without frame tick");
    // Single slot write stores last slot
    last_slot_a: assert property (@(posedge clk) disable iff (!rstn)
        host_wr.en && host_wr.addr == SLOT0_ADDR + ADDR_W'(SLOTS - 1)
        |=> slot_r[SLOTS - 1] == $past(host_wr.data))
        else $error("slot 4 not stored");

    // Each word paired with its slot and address
    word_pair_a: assert property (@(posedge clk) disable iff (!rstn)
        ram_wr.en |-> ram_wr.data == slot_r[word_r]
            && ram_wr.addr == taddr_r + ADDR_W'(word_r))
        else $error("word not paired with its slot");
    // Never more words than slots
    word_range_a: assert property (@(posedge clk) disable iff (!rstn)
        ram_wr.en |-> word_r < CNT_W'(SLOTS))
        else $error("burst ran past the last slot");
    // Done marks the last word
    done_last_a: assert property (@(posedge clk) disable iff (!rstn)
        done |-> ram_wr.en && !busy)
        else $error("done not on last word");
    // Words back to back until done
    back_to_back_a: assert property (@(posedge clk) disable iff (!rstn)
        ram_wr.en && !done |=> ram_wr.en)
        else $error("gap inside copy burst");
    // Writes only right after copying
    write_in_copy_a: assert property (@(posedge clk) disable iff (!rstn)
        ram_wr.en |-> $past(busy))
        else $error("parameter write outside a copy");
    // Zero count copies nothing
    zero_count_a: assert property (@(posedge clk) disable iff (!rstn)
        start && count_r == CNT_ZERO |=> !busy)
        else $error("zero count started a copy");
    // Burst length inside slot range
    len_range_a: assert property (@(posedge clk) disable iff (!rstn)
        busy |-> len_r >= CNT_MIN && len_r <= CNT_MAX)
        else $error("burst length outside slot range");
    // Copy begins only after a tick
    tick_only_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(busy) |-> $past(frame_tick))
        else $error("copy began without frame tick");
    // Pending request kept until serviced
    arm_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        armed_r && !start |=> armed_r)
        else $error("pending request lost");

    one_word_c: cover property (@(posedge clk) disable iff (!rstn)
        $rose(busy) ##1 !busy);
    five_word_c: cover property (@(posedge clk) disable iff (!rstn)
        $rose(busy) ##4 busy ##1 !busy);
    rearm_c: cover property (@(posedge clk) disable iff (!rstn)
        done ##[1:50] cnt_wr);
    busy_tick_c: cover property (@(posedge clk) disable iff (!rstn)
        frame_tick && busy);
    rewrite_c: cover property (@(posedge clk) disable iff (!rstn)
        start && cnt_wr);
endmodule

/* File: core/stage_pkg.sv */
package stage_pkg;
    localparam int          DATA_W     = 32;
    localparam int          ADDR_W     = 16;
    localparam int          SLOTS      = 5;
    localparam int          CNT_W      = 3;
    localparam logic [15:0] SLOT0_ADDR = 16'h6000;
    localparam logic [15:0] TADDR_ADDR = 16'h6005;
    localparam logic [15:0] COUNT_ADDR = 16'h6006;
    localparam logic [2:0]  CNT_MIN    = 3'h1;
    localparam logic [2:0]  CNT_MAX    = 3'h5;
    localparam logic [2:0]  CNT_ZERO   = 3'h0;

    typedef enum logic [0:0] {
        IDLE = 1'b0,
        COPY = 1'b1
    } state_type;

    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } mem_wr_type;
endpackage

/* File: dv/host_model.sv */
module host_model
    import stage_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Host write port
    output mem_wr_type host_wr
);
    timeunit 1ns;
    timeprecision 100ps;
    initial host_wr = '0;
    // Strobe held across writes, so no double drive
    task automatic xfer(input logic [15:0] t, input logic [2:0] n, input int k);
        for (int i = 0; i < k; i++) begin
            @(posedge clk);
            host_wr <= '{1'b1, SLOT0_ADDR + 16'(i), {t, 16'(i)}};
        end
        @(posedge clk);
        host_wr <= '{1'b1, TADDR_ADDR, {16'h0, t}};
        @(posedge clk);
        host_wr <= '{1'b1, COUNT_ADDR, {29'h0, n}};
        @(posedge clk);
        host_wr <= '0;
    endtask
    // Single write, strobe for one cycle
    task automatic put(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        host_wr <= '{1'b1, a, d};
        @(posedge clk);
        host_wr <= '0;
    endtask
endmodule

/* File: dv/safeload_param_transfer_tb.sv */
module safeload_param_transfer_tb
    import stage_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [15:0] t; logic [2:0] n; int k;} row_type;
    logic       clk, rstn, frame_tick, busy, done;
    mem_wr_type host_wr, ram_wr;
    mem_wr_type wq[$];
    int         tq[$];
    int         n_fail, check_count, nd, cyc;
    row_type    rows[8] = '{'{16'h0100, 3'h1, 1}, '{16'h0200, 3'h2, 2}, '{16'h0300, 3'h3, 3},
        '{16'h0400, 3'h4, 4}, '{16'hfffb, 3'h5, 5}, '{16'h0500, 3'h0, 0},
        '{16'h0600, 3'h7, 5}, '{16'h0680, 3'h6, 5}};
    safeload_param_transfer DUT (.clk(clk), .rstn(rstn), .frame_tick(frame_tick),
        .host_wr(host_wr), .ram_wr(ram_wr), .busy(busy), .done(done));
    host_model host (.clk(clk), .host_wr(host_wr));
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge clk);
        frame_tick <= 1'b1;
        @(posedge clk);
        frame_tick <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Word log and hang guard
    always @(posedge clk) begin
        cyc++;
        if (ram_wr.en === 1'b1) begin
            wq.push_back(ram_wr);
            tq.push_back(cyc);
        end
        if (done === 1'b1)
            nd++;
        if (cyc == 5000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        rstn = 0;
        frame_tick = 0;
        repeat (16) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        chk({ram_wr.en, busy, done}, 0);
        foreach (rows[r]) begin
            wq.delete();
            tq.delete();
            nd = 0;
            host.xfer(rows[r].t, rows[r].n, rows[r].k);
            repeat (8) @(posedge clk);
            chk(wq.size(), 0);
            tick();
            chk(wq.size(), rows[r].k);
            foreach (wq[i])
                chk({wq[i].addr, wq[i].data}, {rows[r].t + 16'(i), rows[r].t, 16'(i)});
            if (rows[r].k > 0)
                chk(tq[$] - tq[0], rows[r].k - 1);
            chk(nd, rows[r].k > 0);
            tick();
            chk(wq.size(), rows[r].k);
        end
        // Tick inside a copy is ignored; count on the tick re-arms
        wq.delete();
        nd = 0;
        host.xfer(16'h0800, 3'h5, 5);
        repeat (8) @(posedge clk);
        fork
            tick();
            host.put(COUNT_ADDR, 32'h2);
            begin
                repeat (3) @(posedge clk);
                frame_tick <= 1'b1;
                @(posedge clk);
                frame_tick <= 1'b0;
            end
        join
        chk(wq.size(), 5);
        chk(nd, 1);
        tick();
        chk(wq.size(), 7);
        chk({wq[5].addr, wq[5].data}, {16'h0800, 16'h0800, 16'h0});
        chk(nd, 2);
        // Reset drops an armed request
        host.xfer(16'h0700, 3'h2, 2);
        rstn <= 0;
        @(posedge clk);
        rstn <= 1;
        wq.delete();
        tick();
        chk(wq.size(), 0);
        test_done();
    end
endmodule
